// File: src/ssd_exec.sv
// Purpose: Executes the shift, subtract, bank, pointer, carry and stop instructions.
// Assumes: APB master per the protocol; i_ext_irq is synchronous to i_clk.
// Notes: The register file lives here; one instruction runs at a time.
`timescale 1ns/100ps

module ssd_exec (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Power control.
	input wire logic i_ext_irq,
	output logic o_stop_mode,
	output logic o_busy
);

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_EXEC, S_WAIT, S_STOP} ssd_state_t;

	ssd_state_t state;
	logic [2:0] cnt;
	logic [23:0] ir;
	logic [7:0] flags;
	logic [7:0] win_ptr0;
	logic [7:0] win_ptr1;
	logic [7:0] guard;
	logic [7:0] rf_addr;
	logic [7:0] eff_dst;
	logic [7:0] eff_src;
	logic illegal;
	logic [7:0] rf [0:255];

	////////////////////////////////////////////////////////////////////////////
	// Instruction decode.

	// Working register n maps into the window of one of the two pointers.
	function automatic logic [7:0] work_addr(input logic [3:0] n, input logic [7:0] p0,
		input logic [7:0] p1);
		work_addr = n[3] ? {p1[7:3], n[2:0]} : {p0[7:3], n[2:0]};
	endfunction

	wire [7:0] op = ir[7:0];
	wire [7:0] b1 = ir[15:8];
	wire [7:0] b2 = ir[23:16];
	wire [3:0] form = op[3:0];
	wire is_arith = (op[7:4] == ssd_pkg::FAM_SUB || op[7:4] == ssd_pkg::FAM_BORROW)
		&& form >= ssd_pkg::FORM_RR && form <= ssd_pkg::FORM_IM;
	wire is_work = form == ssd_pkg::FORM_RR || form == ssd_pkg::FORM_RIR;
	wire [7:0] wk_dst = work_addr(b1[7:4], win_ptr0, win_ptr1);
	wire [7:0] wk_src = work_addr(b1[3:0], win_ptr0, win_ptr1);
	wire is_misc = op == ssd_pkg::OPC_BANK0 || op == ssd_pkg::OPC_BANK1
		|| op == ssd_pkg::OPC_CARRY_FORCE || op == ssd_pkg::OPC_PTR || op == ssd_pkg::OPC_STOP;

	// Operand locations, indirection and cycle count of the held instruction.
	wire [7:0] dec_dst_reg = !is_arith ? b1 : is_work ? wk_dst
		: (form == ssd_pkg::FORM_IM) ? b1 : b2;
	wire [7:0] dec_src_reg = (is_arith && is_work) ? wk_src : b1;
	wire dec_src_ind = is_arith && (form == ssd_pkg::FORM_RIR || form == ssd_pkg::FORM_RIR3);
	wire dec_dst_ind = op == ssd_pkg::OPC_ROT_CARRY_IR || op == ssd_pkg::OPC_ARITH_SHIFT_IR;
	wire dec_imm = is_arith && form == ssd_pkg::FORM_IM;
	wire [2:0] dec_ncyc = (is_arith && form != ssd_pkg::FORM_RR)
		? ssd_pkg::CYC_LONG : ssd_pkg::CYC_SHORT;
	wire ssd_pkg::ssd_alu_t dec_alu =
		(op == ssd_pkg::OPC_ROT_CARRY_R || op == ssd_pkg::OPC_ROT_CARRY_IR)
			? ssd_pkg::SSD_ALU_ROT_CARRY :
		(op == ssd_pkg::OPC_ARITH_SHIFT_R || op == ssd_pkg::OPC_ARITH_SHIFT_IR)
			? ssd_pkg::SSD_ALU_ARITH_SHIFT :
		(op == ssd_pkg::OPC_SWAP_R) ? ssd_pkg::SSD_ALU_SWAP :
		(is_arith && op[7:4] == ssd_pkg::FAM_SUB) ? ssd_pkg::SSD_ALU_SUB :
		is_arith ? ssd_pkg::SSD_ALU_BORROW : ssd_pkg::SSD_ALU_NONE;
	wire dec_known = is_misc || dec_alu != ssd_pkg::SSD_ALU_NONE;

	////////////////////////////////////////////////////////////////////////////
	// Operand fetch and ALU.

	wire [7:0] dst_val = rf[eff_dst];
	wire [7:0] src_val = dec_imm ? b2 : rf[eff_src];
	wire [7:0] alu_res;
	wire [7:0] alu_flags;
	wire alu_wr;
	wire exec = state == S_EXEC;
	wire stop_ok = guard == ssd_pkg::GUARD_KEY;

	ssd_alu u_alu (
		.i_op(dec_alu),
		.i_dst(dst_val),
		.i_src(src_val),
		.i_flags(flags),
		.o_res(alu_res),
		.o_flags(alu_flags),
		.o_wr(alu_wr)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode.

	wire busy = state == S_ADDR || state == S_EXEC || state == S_WAIT;
	wire in_stop = state == S_STOP;
	wire mapped = i_paddr == ssd_pkg::REG_INSTR || i_paddr == ssd_pkg::REG_FLAGS
		|| i_paddr == ssd_pkg::REG_PTRS || i_paddr == ssd_pkg::REG_GUARD
		|| i_paddr == ssd_pkg::REG_STATUS || i_paddr == ssd_pkg::REG_RF_ADDR
		|| i_paddr == ssd_pkg::REG_RF_DATA;
	wire bus_err = !mapped || (i_pwrite && (busy || in_stop || i_paddr == ssd_pkg::REG_STATUS));
	wire apb_wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
	wire start = apb_wr && i_paddr == ssd_pkg::REG_INSTR;
	wire [31:0] rd_data =
		(i_paddr == ssd_pkg::REG_INSTR) ? {8'h00, ir} :
		(i_paddr == ssd_pkg::REG_FLAGS) ? {24'h000000, flags} :
		(i_paddr == ssd_pkg::REG_PTRS) ? {16'h0000, win_ptr1, win_ptr0} :
		(i_paddr == ssd_pkg::REG_GUARD) ? {24'h000000, guard} :
		(i_paddr == ssd_pkg::REG_STATUS) ? {29'h0, illegal, in_stop, busy} :
		(i_paddr == ssd_pkg::REG_RF_ADDR) ? {24'h000000, rf_addr} :
		(i_paddr == ssd_pkg::REG_RF_DATA) ? {24'h000000, rf[rf_addr]} : 32'h00000000;

	// One wait state, so read data and error come from flip-flops.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end
		else if (i_psel && i_penable && !o_pready)
		begin
			o_pready <= 1'b1;
			o_pslverr <= bus_err;
			o_prdata <= i_pwrite ? 32'h00000000 : rd_data;
		end
		else
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: address resolve, execute, then pad to the cycle count.

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state <= S_IDLE;
			cnt <= ssd_pkg::CYC_FIRST;
		end
		else
		begin
			cnt <= cnt + 3'h1;
			unique case (state)
				S_IDLE:
				begin
					cnt <= ssd_pkg::CYC_FIRST;
					if (start)
						state <= S_ADDR;
				end
				S_ADDR:
					state <= S_EXEC;
				S_EXEC:
					state <= (op == ssd_pkg::OPC_STOP && stop_ok) ? S_STOP : S_WAIT;
				S_WAIT:
					if (cnt == dec_ncyc)
						state <= S_IDLE;
				S_STOP:
					if (i_ext_irq)
						state <= S_IDLE;
			endcase
		end
	end

	// Indirect forms read the named register to find the operand address.
	always_ff @(posedge i_clk)
	begin
		if (state == S_ADDR)
		begin
			eff_dst <= dec_dst_ind ? rf[dec_dst_reg] : dec_dst_reg;
			eff_src <= dec_src_ind ? rf[dec_src_reg] : dec_src_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Architectural state: written by software when idle, by execution when busy.

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			ir <= 24'h000000;
			flags <= ssd_pkg::FLAGS_RST;
			win_ptr0 <= ssd_pkg::WIN_PTR0_RST;
			win_ptr1 <= ssd_pkg::WIN_PTR1_RST;
			guard <= ssd_pkg::GUARD_RST;
			rf_addr <= 8'h00;
			illegal <= 1'b0;
		end
		else if (exec)
		begin
			illegal <= !dec_known;
			if (alu_wr)
				rf[eff_dst] <= alu_res;
			if (dec_alu != ssd_pkg::SSD_ALU_NONE)
				flags <= alu_flags;
			else if (op == ssd_pkg::OPC_BANK0)
				flags[ssd_pkg::FLG_BANK] <= 1'b0;
			else if (op == ssd_pkg::OPC_BANK1)
				flags[ssd_pkg::FLG_BANK] <= 1'b1;
			else if (op == ssd_pkg::OPC_CARRY_FORCE)
				flags[ssd_pkg::FLG_C] <= 1'b1;
			if (op == ssd_pkg::OPC_PTR && b1[1:0] == ssd_pkg::PSEL_ZERO)
				win_ptr0[7:3] <= b1[7:3];
			if (op == ssd_pkg::OPC_PTR && b1[1:0] == ssd_pkg::PSEL_ONE)
				win_ptr1[7:3] <= b1[7:3];
			if (op == ssd_pkg::OPC_PTR && b1[1:0] == ssd_pkg::PSEL_BOTH)
			begin
				win_ptr0[7:3] <= {b1[7:4], 1'b0};
				win_ptr1[7:3] <= {b1[7:4], 1'b1};
			end
		end
		else if (apb_wr)
		begin
			if (i_paddr == ssd_pkg::REG_INSTR)
				ir <= i_pwdata[23:0];
			if (i_paddr == ssd_pkg::REG_FLAGS)
				flags <= i_pwdata[7:0];
			if (i_paddr == ssd_pkg::REG_PTRS)
				{win_ptr1, win_ptr0} <= i_pwdata[15:0];
			if (i_paddr == ssd_pkg::REG_GUARD)
				guard <= i_pwdata[7:0];
			if (i_paddr == ssd_pkg::REG_RF_ADDR)
				rf_addr <= i_pwdata[7:0];
			if (i_paddr == ssd_pkg::REG_RF_DATA)
				rf[rf_addr] <= i_pwdata[7:0];
		end
	end

	// Stop mode gates the core clocks outside this block.
	assign o_stop_mode = in_stop;
	assign o_busy = busy;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking ssd_cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	rot_bits_a: assert property (exec && dec_alu == ssd_pkg::SSD_ALU_ROT_CARRY |=>
		rf[$past(eff_dst)] == {$past(flags[ssd_pkg::FLG_C]), $past(dst_val[7:1])}
		&& flags[ssd_pkg::FLG_C] == $past(dst_val[0]))
		else $error("Rotate through carry gave wrong bits.");
	bank_zero_a: assert property (exec && op == ssd_pkg::OPC_BANK0 |=>
		!flags[ssd_pkg::FLG_BANK] && flags[7:1] == $past(flags[7:1]))
		else $error("Bank zero select failed.");
	bank_one_a: assert property (exec && op == ssd_pkg::OPC_BANK1 |=>
		flags[ssd_pkg::FLG_BANK] && $stable(flags[7:1]))
		else $error("Bank one select failed.");
	borrow_result_a: assert property (exec && dec_alu == ssd_pkg::SSD_ALU_BORROW |=>
		rf[$past(eff_dst)] == 8'($past(dst_val) - $past(src_val)
		- {7'h00, $past(flags[ssd_pkg::FLG_C])}))
		else $error("Borrow subtract result wrong.");
	sub_result_a: assert property (exec && dec_alu == ssd_pkg::SSD_ALU_SUB |=>
		rf[$past(eff_dst)] == 8'($past(dst_val) - $past(src_val)))
		else $error("Subtract result wrong.");
	sub_flags_a: assert property (exec && (dec_alu == ssd_pkg::SSD_ALU_SUB
		|| dec_alu == ssd_pkg::SSD_ALU_BORROW) |=> flags[ssd_pkg::FLG_D]
		&& flags[ssd_pkg::FLG_C] == ({1'b0, $past(src_val)} + {8'h00,
		$past(dec_alu == ssd_pkg::SSD_ALU_BORROW && flags[ssd_pkg::FLG_C])}
		> {1'b0, $past(dst_val)}))
		else $error("Subtract flags wrong.");
	carry_force_a: assert property (exec && op == ssd_pkg::OPC_CARRY_FORCE |=>
		flags[ssd_pkg::FLG_C] && flags[6:0] == $past(flags[6:0]))
		else $error("Carry force failed.");
	arith_shift_a: assert property (exec && dec_alu == ssd_pkg::SSD_ALU_ARITH_SHIFT
		|=>
		rf[$past(eff_dst)] == {$past(dst_val[7]), $past(dst_val[7:1])}
		&& !flags[ssd_pkg::FLG_V] && $stable(flags[3:2]))
		else $error("Arithmetic shift wrong.");
	ptr_one_a: assert property (exec && op == ssd_pkg::OPC_PTR
		&& b1[1:0] == ssd_pkg::PSEL_ONE |=> win_ptr1[7:3] == $past(b1[7:3])
		&& $stable(win_ptr0))
		else $error("Pointer one load wrong.");
	ptr_both_a: assert property (exec && op == ssd_pkg::OPC_PTR
		&& b1[1:0] == ssd_pkg::PSEL_BOTH |=> !win_ptr0[3] && win_ptr1[3]
		&& win_ptr0[7:4] == $past(b1[7:4]) && win_ptr1[7:4] == $past(b1[7:4])
		&& $stable(flags))
		else $error("Dual pointer load wrong.");
	stop_hold_a: assert property (in_stop && !i_ext_irq |=>
		in_stop && $stable(flags) && $stable(win_ptr0) && $stable(guard))
		else $error("Stop mode lost state.");
	stop_guard_a: assert property (exec && op == ssd_pkg::OPC_STOP |=>
		in_stop == $past(stop_ok))
		else $error("Stop guard not honoured.");
	swap_nib_a: assert property (exec && dec_alu == ssd_pkg::SSD_ALU_SWAP |=>
		rf[$past(eff_dst)] == {$past(dst_val[3:0]), $past(dst_val[7:4])}
		&& $stable(flags[3:2]))
		else $error("Nibble swap wrong.");
	ind_addr_a: assert property (state == S_ADDR && dec_src_ind |=>
		eff_src == $past(rf[dec_src_reg]))
		else $error("Indirect source not resolved.");
	busy_len_a: assert property (start
		&& !(i_pwdata[7:0] == ssd_pkg::OPC_STOP && stop_ok) |=> busy[*4])
		else $error("Instruction shorter than four cycles.");
	stop_entry_a: assert property (start
		&& i_pwdata[7:0] == ssd_pkg::OPC_STOP && stop_ok |=> busy[*2] ##1 in_stop)
		else $error("Stop entry sequence wrong.");

endmodule

// File: src/ssd_pkg.sv
// Purpose: Shared constants and types for the shift and subtract datapath.
// Assumes: One 200 MHz clock, synchronous active-high reset, APB register access.
// Notes: Opcodes, flag positions, register map and reset values of the datapath.
// Behaviour
// - Indirect rotate right through carry, code c1.
// - Direct rotate right through carry, code c0.
// - Code 4f clears bank bit, flags otherwise kept.
// - Code 5f sets bank bit.
// - Borrow subtract: dst minus src minus carry.
// - Borrow subtract sets carry, zero, sign, overflow.
// - Subtracts force decimal flag, half flag marks borrow.
// - Plain subtract: dst minus src into dst.
// - Plain subtract sets carry, zero, sign, overflow.
// - Code df forces carry, other flags kept.
// - Arithmetic right shift keeps sign bit.
// - Shift flags: carry out, overflow cleared.
// - Pointer load selects pointer by low bits.
// - Stop halts clocks, keeps state, interrupt exits.
// - Stop only obeyed with guard key loaded.
// - Nibble swap, zero and sign follow result.

package ssd_pkg;

	// Opcodes handled by this unit.
	localparam logic [7:0] OPC_ROT_CARRY_R = 8'hc0;
	localparam logic [7:0] OPC_ROT_CARRY_IR = 8'hc1;
	localparam logic [7:0] OPC_BANK0 = 8'h4f;
	localparam logic [7:0] OPC_BANK1 = 8'h5f;
	localparam logic [7:0] OPC_CARRY_FORCE = 8'hdf;
	localparam logic [7:0] OPC_ARITH_SHIFT_R = 8'hd0;
	localparam logic [7:0] OPC_ARITH_SHIFT_IR = 8'hd1;
	localparam logic [7:0] OPC_PTR = 8'h31;
	localparam logic [7:0] OPC_STOP = 8'h7f;
	localparam logic [7:0] OPC_SWAP_R = 8'hf0;

	// Subtract families and their operand forms (low opcode nibble).
	localparam logic [3:0] FAM_SUB = 4'h2;
	localparam logic [3:0] FAM_BORROW = 4'h3;
	localparam logic [3:0] FORM_RR = 4'h2;
	localparam logic [3:0] FORM_RIR = 4'h3;
	localparam logic [3:0] FORM_RR3 = 4'h4;
	localparam logic [3:0] FORM_RIR3 = 4'h5;
	localparam logic [3:0] FORM_IM = 4'h6;

	// Flag bit positions.
	localparam int FLG_C = 7;
	localparam int FLG_Z = 6;
	localparam int FLG_S = 5;
	localparam int FLG_V = 4;
	localparam int FLG_D = 3;
	localparam int FLG_H = 2;
	localparam int FLG_BANK = 0;

	// Pointer load selector values in the low source bits.
	localparam logic [1:0] PSEL_BOTH = 2'h0;
	localparam logic [1:0] PSEL_ONE = 2'h1;
	localparam logic [1:0] PSEL_ZERO = 2'h2;

	// Stop guard key and instruction lengths in clock cycles.
	localparam logic [7:0] GUARD_KEY = 8'ha5;
	localparam logic [2:0] CYC_SHORT = 3'h4;
	localparam logic [2:0] CYC_LONG = 3'h6;
	localparam logic [2:0] CYC_FIRST = 3'h1;

	// APB byte addresses.
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_FLAGS = 8'h04;
	localparam logic [7:0] REG_PTRS = 8'h08;
	localparam logic [7:0] REG_GUARD = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RF_ADDR = 8'h14;
	localparam logic [7:0] REG_RF_DATA = 8'h18;

	// Reset values.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] WIN_PTR0_RST = 8'hc0;
	localparam logic [7:0] WIN_PTR1_RST = 8'hc8;
	localparam logic [7:0] GUARD_RST = 8'h00;

	// Operation class driven into the ALU.
	typedef enum logic [2:0] {
		SSD_ALU_NONE,
		SSD_ALU_ROT_CARRY,
		SSD_ALU_SUB,
		SSD_ALU_BORROW,
		SSD_ALU_ARITH_SHIFT,
		SSD_ALU_SWAP
	} ssd_alu_t;

endpackage

// File: src/ssd_alu.sv
// Purpose: Combinational result and flag logic for rotate, shift, swap and subtract.
// Assumes: Operands are already fetched; the caller writes the result back.
// Notes: Flags not named by an operation pass through unchanged.
`timescale 1ns/100ps

module ssd_alu (
	// Operation and operands.
	input wire ssd_pkg::ssd_alu_t i_op,
	input wire logic [7:0] i_dst,
	input wire logic [7:0] i_src,
	input wire logic [7:0] i_flags,
	// Results.
	output logic [7:0] o_res,
	output logic [7:0] o_flags,
	output logic o_wr
);

	logic sub_cin;
	logic [8:0] sub_sum;
	logic [4:0] sub_low;

	// Subtract is dst plus the complement of src plus an inverted borrow.
	assign sub_cin = (i_op == ssd_pkg::SSD_ALU_BORROW) ? ~i_flags[ssd_pkg::FLG_C] : 1'b1;
	assign sub_sum = {1'b0, i_dst} + {1'b0, ~i_src} + {8'h00, sub_cin};
	assign sub_low = {1'b0, i_dst[3:0]} + {1'b0, ~i_src[3:0]} + {4'h0, sub_cin};

	// Result and flag selection per operation.
	always_comb
	begin
		o_res = i_dst;
		o_flags = i_flags;
		o_wr = 1'b1;
		unique case (i_op)
			ssd_pkg::SSD_ALU_ROT_CARRY:
			begin
				o_res = {i_flags[ssd_pkg::FLG_C], i_dst[7:1]};
				o_flags[ssd_pkg::FLG_C] = i_dst[0];
				o_flags[ssd_pkg::FLG_V] = i_flags[ssd_pkg::FLG_C] ^ i_dst[7];
			end
			ssd_pkg::SSD_ALU_SUB, ssd_pkg::SSD_ALU_BORROW:
			begin
				o_res = sub_sum[7:0];
				o_flags[ssd_pkg::FLG_C] = ~sub_sum[8];
				o_flags[ssd_pkg::FLG_V] = (i_dst[7] != i_src[7]) && (sub_sum[7] == i_src[7]);
				o_flags[ssd_pkg::FLG_D] = 1'b1;
				o_flags[ssd_pkg::FLG_H] = ~sub_low[4];
			end
			ssd_pkg::SSD_ALU_ARITH_SHIFT:
			begin
				o_res = {i_dst[7], i_dst[7:1]};
				o_flags[ssd_pkg::FLG_C] = i_dst[0];
				o_flags[ssd_pkg::FLG_V] = 1'b0;
			end
			ssd_pkg::SSD_ALU_SWAP:
				o_res = {i_dst[3:0], i_dst[7:4]};
			ssd_pkg::SSD_ALU_NONE:
				o_wr = 1'b0;
		endcase
		// Zero and sign follow the result for every class that writes.
		if (o_wr)
		begin
			o_flags[ssd_pkg::FLG_Z] = (o_res == 8'h00);
			o_flags[ssd_pkg::FLG_S] = o_res[7];
		end
	end

endmodule

// File: dv/ssd_exec_bench.sv
// Purpose: Self-checking bench for the shift and subtract execution unit.
// Assumes: The unit answers APB in two access cycles and flags busy per instruction.
// Notes: Expected results are worked out by hand from the instruction behaviour.
`timescale 1ns/100ps

// Compares two values, counts the comparison and reports a mismatch.
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module ssd_exec_bench;

	// Stimulus and observed signals.
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic irq = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic stop_mode;
	logic busy;
	int n_errors = 0;
	int n_compared = 0;
	logic [31:0] rd;
	logic err;

	////////////////////////////////////////////////////////////////////////////////////////
	// Clock of 5 ns period.
	always #2.5 clk = ~clk;

	// Unit under test.
	ssd_exec dut (
		.i_clk(clk),
		.i_sys_rst(rst),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_ext_irq(irq),
		.o_stop_mode(stop_mode),
		.o_busy(busy)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task finish_test;
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			@(posedge clk);
		end
		`CHK(pready, 1'b1)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Loads one register file byte.
	task rf(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, ssd_pkg::REG_RF_ADDR, {24'h0, a});
		apb(1'b1, ssd_pkg::REG_RF_DATA, {24'h0, v});
	endtask

	// Reads one register file byte and compares it.
	task rf_chk(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, ssd_pkg::REG_RF_ADDR, {24'h0, a});
		apb(1'b0, ssd_pkg::REG_RF_DATA, 32'h0);
		`CHK(rd, {24'h0, v})
	endtask

	// Starts an instruction and counts its busy cycles.
	task exec(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2,
		input logic [3:0] nexp);
		logic [3:0] n;
		n = 4'h0;
		apb(1'b1, ssd_pkg::REG_INSTR, {8'h00, b2, b1, opc});
		#1;
		while (busy === 1'b1 && n < 4'hf)
		begin
			n++;
			@(posedge clk);
			#1;
		end
		`CHK(n, nexp)
	endtask

	// Runs an instruction from given flags, then checks one byte and the flags.
	task op(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2,
		input logic [7:0] fin, input logic [7:0] ca, input logic [7:0] er,
		input logic [7:0] ef);
		logic lg;
		lg = (opc[7:4] == 4'h2 || opc[7:4] == 4'h3) && opc[3:0] >= 4'h3 && opc[3:0] <= 4'h6;
		apb(1'b1, ssd_pkg::REG_FLAGS, {24'h0, fin});
		exec(opc, b1, b2, lg ? 4'h6 : 4'h4);
		rf_chk(ca, er);
		apb(1'b0, ssd_pkg::REG_FLAGS, 32'h0);
		`CHK(rd, {24'h0, ef})
	endtask

	// Runs a pointer load from the reset pointer values.
	task ptr(input logic [7:0] imm, input logic [31:0] exp);
		apb(1'b1, ssd_pkg::REG_PTRS, 32'h0000c8c0);
		apb(1'b1, ssd_pkg::REG_FLAGS, 32'h5d);
		exec(8'h31, imm, 8'h00, 4'h4);
		apb(1'b0, ssd_pkg::REG_PTRS, 32'h0);
		`CHK(rd, exp)
		apb(1'b0, ssd_pkg::REG_FLAGS, 32'h0);
		`CHK(rd, 32'h5d)
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	// Cuts a hung run short.
	initial
	begin
		#200000;
		n_errors++;
		finish_test;
	end

	// Main sequence.
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, ssd_pkg::REG_FLAGS, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, ssd_pkg::REG_PTRS, 32'h0);
		`CHK(rd, 32'h0000c8c0)
		apb(1'b0, ssd_pkg::REG_GUARD, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h1c, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, ssd_pkg::REG_STATUS, 32'h7);
		`CHK(err, 1'b1)
		// Rotate, shift and swap.
		rf(8'h00, 8'h55);
		op(8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2a, 8'h80);
		rf(8'h01, 8'h02);
		rf(8'h02, 8'h17);
		op(8'hc1, 8'h01, 8'h00, 8'h8c, 8'h02, 8'h8b, 8'hbc);
		rf_chk(8'h01, 8'h02);
		rf(8'h00, 8'h9a);
		op(8'hd0, 8'h00, 8'h00, 8'h9c, 8'h00, 8'hcd, 8'h2c);
		rf(8'h02, 8'h03);
		rf(8'h03, 8'hbc);
		op(8'hd1, 8'h02, 8'h00, 8'h9c, 8'h03, 8'hde, 8'h2c);
		rf(8'h00, 8'h3e);
		op(8'hf0, 8'h00, 8'h00, 8'h9c, 8'h00, 8'he3, 8'hbc);
		rf(8'h04, 8'h00);
		op(8'hf0, 8'h04, 8'h00, 8'h9c, 8'h04, 8'h00, 8'hdc);
		// Plain subtract in every operand form.
		rf(8'h01, 8'h21);
		rf(8'h02, 8'h03);
		op(8'h24, 8'h02, 8'h01, 8'h00, 8'h01, 8'h1e, 8'h0c);
		rf_chk(8'h02, 8'h03);
		rf(8'h01, 8'h21);
		op(8'h26, 8'h01, 8'h90, 8'h00, 8'h01, 8'h91, 8'hb8);
		rf(8'h01, 8'h21);
		op(8'h26, 8'h01, 8'h65, 8'h00, 8'h01, 8'hbc, 8'hac);
		rf(8'h05, 8'h42);
		op(8'h26, 8'h05, 8'h42, 8'h80, 8'h05, 8'h00, 8'h48);
		rf(8'hc1, 8'h12);
		rf(8'hc2, 8'h03);
		op(8'h22, 8'h12, 8'h00, 8'h00, 8'hc1, 8'h0f, 8'h0c);
		rf(8'hc9, 8'h12);
		rf(8'hca, 8'h03);
		op(8'h22, 8'h9a, 8'h00, 8'h00, 8'hc9, 8'h0f, 8'h0c);
		rf(8'hc1, 8'h12);
		rf(8'h03, 8'h0a);
		op(8'h23, 8'h12, 8'h00, 8'h00, 8'hc1, 8'h08, 8'h0c);
		rf(8'h01, 8'h21);
		op(8'h25, 8'h02, 8'h01, 8'h00, 8'h01, 8'h17, 8'h0c);
		// Subtract with borrow in every operand form.
		rf(8'hc1, 8'h10);
		op(8'h32, 8'h12, 8'h00, 8'h80, 8'hc1, 8'h0c, 8'h0c);
		rf(8'hc1, 8'h10);
		op(8'h33, 8'h12, 8'h00, 8'h80, 8'hc1, 8'h05, 8'h0c);
		rf(8'h01, 8'h20);
		op(8'h34, 8'h02, 8'h01, 8'h80, 8'h01, 8'h1c, 8'h0c);
		rf_chk(8'h02, 8'h03);
		rf(8'h01, 8'h20);
		op(8'h35, 8'h02, 8'h01, 8'h80, 8'h01, 8'h15, 8'h0c);
		rf(8'h01, 8'h20);
		op(8'h36, 8'h01, 8'h8a, 8'h80, 8'h01, 8'h95, 8'hbc);
		rf(8'h01, 8'h20);
		op(8'h36, 8'h01, 8'h8a, 8'h00, 8'h01, 8'h96, 8'hbc);
		// Bank select and carry force leave a bystander byte alone.
		rf(8'h06, 8'h77);
		op(8'h4f, 8'h00, 8'h00, 8'hfd, 8'h06, 8'h77, 8'hfc);
		op(8'h5f, 8'h00, 8'h00, 8'hfc, 8'h06, 8'h77, 8'hfd);
		op(8'hdf, 8'h00, 8'h00, 8'h7d, 8'h06, 8'h77, 8'hfd);
		op(8'hdf, 8'h00, 8'h00, 8'hfd, 8'h06, 8'h77, 8'hfd);
		// A write while busy is refused.
		apb(1'b1, ssd_pkg::REG_FLAGS, 32'h0);
		apb(1'b1, ssd_pkg::REG_INSTR, 32'hdf);
		apb(1'b1, ssd_pkg::REG_FLAGS, 32'h44);
		`CHK(err, 1'b1)
		repeat (4) @(posedge clk);
		apb(1'b0, ssd_pkg::REG_FLAGS, 32'h0);
		`CHK(rd, 32'h80)
		// Pointer loads.
		ptr(8'h40, 32'h00004840);
		ptr(8'h52, 32'h0000c850);
		ptr(8'h69, 32'h000068c0);
		ptr(8'h73, 32'h0000c8c0);
		// Stop without and with the guard key.
		apb(1'b1, ssd_pkg::REG_GUARD, 32'h3c);
		exec(8'h7f, 8'h00, 8'h00, 4'h4);
		`CHK(stop_mode, 1'b0)
		apb(1'b1, ssd_pkg::REG_GUARD, 32'ha5);
		rf(8'h07, 8'h5a);
		apb(1'b1, ssd_pkg::REG_FLAGS, 32'h24);
		exec(8'h7f, 8'h00, 8'h00, 4'h2);
		repeat (5) @(posedge clk);
		`CHK(stop_mode, 1'b1)
		apb(1'b1, ssd_pkg::REG_FLAGS, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
		`CHK(rd, 32'h2)
		apb(1'b0, ssd_pkg::REG_FLAGS, 32'h0);
		`CHK(rd, 32'h24)
		apb(1'b0, ssd_pkg::REG_RF_DATA, 32'h0);
		`CHK(rd, 32'h5a)
		irq <= 1'b1;
		repeat (3) @(posedge clk);
		irq <= 1'b0;
		#1;
		`CHK(stop_mode, 1'b0)
		// An opcode outside the set is flagged and does nothing.
		exec(8'hcf, 8'h00, 8'h00, 4'h4);
		apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
		`CHK(rd, 32'h4)
		finish_test;
	end

endmodule
